// *** design/xds_pkg.sv ***
package xds_pkg;
  localparam int          CLKS_PER_MC     = 4;
  localparam logic [1:0]  STATE_C1        = 2'h0;
  localparam logic [1:0]  STATE_C2        = 2'h1;
  localparam logic [1:0]  STATE_C3        = 2'h2;
  localparam logic [1:0]  STATE_C4        = 2'h3;
  localparam int          STRETCH_LSB     = 0;
  localparam int          STRETCH_W       = 3;
  localparam logic [7:0]  CLKCTL_RESET    = 8'h01;
  localparam int          HOLD_EN_BIT     = 7;
  localparam logic [7:0]  MEMMAP_RESET    = 8'h00;
  localparam logic [7:0]  UNLOCK_KEY1     = 8'haa;
  localparam logic [7:0]  UNLOCK_KEY2     = 8'h55;
  localparam logic [1:0]  UNLOCK_WINDOW   = 2'h3;
  typedef enum logic [1:0] {XDS_IDLE, XDS_FETCH, XDS_ACCESS, XDS_END} xds_phase_t;
endpackage

// *** design/xds_timing_if.sv ***
`timescale 1ns/1ps
interface xds_timing_if;
  logic       mcTick;
  logic [1:0] clkState;
  modport src (output mcTick, output clkState);
  modport dst (input mcTick, input clkState);
endinterface

// *** design/xds_state_gen.sv ***
`timescale 1ns/1ps
module xds_state_gen
  import xds_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  xds_timing_if.src tim
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  always_comb begin
    next_cnt = cnt + 2'h1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= STATE_C1;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign tim.clkState = cnt;
  assign tim.mcTick   = (cnt == STATE_C4);
endmodule

// *** design/xds_stretch_wait.sv ***
`timescale 1ns/1ps
module xds_stretch_wait
  import xds_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // CPU request, taken at the start of a machine cycle
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   cpuHold,
  output logic                   reqDone,
  output logic [DATA_W-1:0]      reqRdata,
  output logic                   cycleStart,
  // Special register writes
  input  wire logic              sfrWrite,
  input  wire logic              sfrSelClk,
  input  wire logic              sfrSelMap,
  input  wire logic              sfrSelKey,
  input  wire logic [7:0]        sfrWdata,
  output logic [7:0]             clockControlReg,
  output logic [7:0]             memoryMapReg,
  // External memory pins
  input  wire logic              holdRequestN,
  input  wire logic [DATA_W-1:0] extDataIn,
  output logic [ADDR_W-1:0]      extAddr,
  output logic [DATA_W-1:0]      extDataOut,
  output logic                   extDataOe,
  output logic                   readStrobeN,
  output logic                   writeStrobeN
);
  // Elaboration checks; the machine-cycle counter is four bits wide
  if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_width
    $error("xds_stretch_wait: bad width");
  end
  if (STRETCH_W > 3) begin : g_bad_stretch
    $error("xds_stretch_wait: stretch field too wide for cycle counter");
  end

  xds_timing_if tim ();
  xds_state_gen u_gen (
    .clock (clock),
    .rst   (rst),
    .tim   (tim)
  );

  // Pin synchroniser; the first stage feeds only the second
  logic holdSync1;
  logic holdSync2;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      holdSync1 <= 1'b1;
      holdSync2 <= 1'b1;
    end else begin
      holdSync1 <= holdRequestN;
      holdSync2 <= holdSync1;
    end
  end

  // Register file with timed unlock
  logic [7:0] clkReg;
  logic [7:0] mapReg;
  logic [1:0] keyStage;
  logic [1:0] keyTimer;
  logic [7:0] next_clkReg;
  logic [7:0] next_mapReg;
  logic [1:0] next_keyStage;
  logic [1:0] next_keyTimer;
  always_comb begin
    next_clkReg   = clkReg;
    next_mapReg   = mapReg;
    next_keyStage = keyStage;
    next_keyTimer = (keyTimer != 2'h0) ? keyTimer - 2'h1 : 2'h0;
    if (keyStage == 2'h2 && keyTimer == 2'h0) begin
      next_keyStage = 2'h0;
    end
    if (sfrWrite && sfrSelClk) begin
      next_clkReg = sfrWdata;
    end
    if (sfrWrite && sfrSelKey) begin
      if (sfrWdata == UNLOCK_KEY1) begin
        next_keyStage = 2'h1;
      end else if (sfrWdata == UNLOCK_KEY2 && keyStage == 2'h1) begin
        next_keyStage = 2'h2;
        next_keyTimer = UNLOCK_WINDOW;
      end else begin
        next_keyStage = 2'h0;
      end
    end
    if (sfrWrite && sfrSelMap) begin
      // Hold enable moves only when unlocked; other bits are free
      next_mapReg[HOLD_EN_BIT-1:0] = sfrWdata[HOLD_EN_BIT-1:0];
      if (keyStage == 2'h2) begin
        next_mapReg[HOLD_EN_BIT] = sfrWdata[HOLD_EN_BIT];
      end
      next_keyStage = 2'h0;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clkReg   <= CLKCTL_RESET;
      mapReg   <= MEMMAP_RESET;
      keyStage <= 2'h0;
      keyTimer <= 2'h0;
    end else begin
      clkReg   <= next_clkReg;
      mapReg   <= next_mapReg;
      keyStage <= next_keyStage;
      keyTimer <= next_keyTimer;
    end
  end

  // Access sequencer
  xds_phase_t        phase;
  xds_phase_t        next_phase;
  logic [3:0]        mcLeft;
  logic [3:0]        next_mcLeft;
  logic              isWrite;
  logic              next_isWrite;
  logic [ADDR_W-1:0] addrQ;
  logic [ADDR_W-1:0] next_addrQ;
  logic [DATA_W-1:0] wdataQ;
  logic [DATA_W-1:0] next_wdataQ;
  logic [DATA_W-1:0] rdataQ;
  logic [DATA_W-1:0] next_rdataQ;
  logic              strobe;
  logic              next_strobe;
  logic              holdQ;
  logic              next_holdQ;
  logic              doneQ;
  logic              next_doneQ;
  logic [STRETCH_W-1:0] stretch;
  logic              holdEn;
  logic              mcEdge;

  assign stretch = clkReg[STRETCH_LSB +: STRETCH_W];
  assign holdEn  = mapReg[HOLD_EN_BIT];
  assign mcEdge  = tim.mcTick;

  // Hold is sampled in the C3 state that precedes the strobe's release
  function automatic logic holdPoint(input logic [STRETCH_W-1:0] s,
                                     input logic [3:0]           left,
                                     input logic [1:0]           st);
    return (s != '0) && (left == 4'h1) && (st == STATE_C3);
  endfunction

  // Strobe is released after C1 of the last access cycle
  function automatic logic strobeEnd(input logic [STRETCH_W-1:0] s,
                                     input logic [3:0]           left,
                                     input logic [1:0]           st);
    return (s != '0) && (left == 4'h0) && (st == STATE_C1);
  endfunction

  always_comb begin
    next_phase   = phase;
    next_mcLeft  = mcLeft;
    next_isWrite = isWrite;
    next_addrQ   = addrQ;
    next_wdataQ  = wdataQ;
    next_rdataQ  = rdataQ;
    next_strobe  = strobe;
    next_holdQ   = holdQ;
    next_doneQ   = 1'b0;
    case (phase)
      XDS_IDLE: begin
        if (mcEdge && reqValid) begin
          next_phase   = XDS_FETCH;
          next_isWrite = reqWrite;
          next_addrQ   = reqAddr;
          next_wdataQ  = reqWdata;
          next_holdQ   = 1'b0;
        end
      end
      XDS_FETCH: begin
        if (mcEdge) begin
          next_phase  = XDS_ACCESS;
          next_mcLeft = {1'b0, stretch};
        end
      end
      XDS_ACCESS: begin
        // Stretch 0: strobe C2..C3 (2 clocks); else C2 of first to C1 of last
        // Limitation: at stretch 0 no C3 precedes the strobe's end, so hold is not seen
        if (stretch == '0) begin
          next_strobe = (tim.clkState == STATE_C1) || (tim.clkState == STATE_C2);
        end else if (tim.clkState == STATE_C1 && mcLeft == {1'b0, stretch}) begin
          next_strobe = 1'b1;
        end else if (strobeEnd(stretch, mcLeft, tim.clkState)) begin
          next_strobe = 1'b0;
        end
        if (holdPoint(stretch, mcLeft, tim.clkState)) begin
          next_holdQ = holdEn && !holdSync2;
        end
        if (mcEdge) begin
          if (mcLeft == 4'h1 && holdQ) begin
            // Counter stays put: one whole cycle inserted, strobe kept active
            next_holdQ = 1'b0;
          end else if (mcLeft != 4'h0) begin
            next_mcLeft = mcLeft - 4'h1;
          end else begin
            next_phase  = XDS_END;
            next_strobe = 1'b0;
          end
        end
        if (strobe && !isWrite) begin
          next_rdataQ = extDataIn;
        end
      end
      XDS_END: begin
        next_phase = XDS_IDLE;
        next_doneQ = 1'b1;
        next_strobe = 1'b0;
      end
      default: begin
        next_phase = XDS_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase   <= XDS_IDLE;
      mcLeft  <= 4'h0;
      isWrite <= 1'b0;
      addrQ   <= '0;
      wdataQ  <= '0;
      rdataQ  <= '0;
      strobe  <= 1'b0;
      holdQ   <= 1'b0;
      doneQ   <= 1'b0;
    end else begin
      phase   <= next_phase;
      mcLeft  <= next_mcLeft;
      isWrite <= next_isWrite;
      addrQ   <= next_addrQ;
      wdataQ  <= next_wdataQ;
      rdataQ  <= next_rdataQ;
      strobe  <= next_strobe;
      holdQ   <= next_holdQ;
      doneQ   <= next_doneQ;
    end
  end

  // Registered outputs; only external moves stall the CPU
  logic busyQ;
  logic startQ;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busyQ  <= 1'b0;
      startQ <= 1'b0;
    end else begin
      busyQ  <= (next_phase != XDS_IDLE);
      startQ <= mcEdge;
    end
  end

  // Pin drivers come from flops so the strobes cannot glitch
  logic oeNQ;
  logic rdNQ;
  logic wrNQ;
  logic next_oeNQ;
  logic next_rdNQ;
  logic next_wrNQ;
  always_comb begin
    next_oeNQ = !(next_isWrite && next_phase != XDS_IDLE);
    next_rdNQ = !(next_strobe && !next_isWrite);
    next_wrNQ = !(next_strobe && next_isWrite);
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oeNQ <= 1'b1;
      rdNQ <= 1'b1;
      wrNQ <= 1'b1;
    end else begin
      oeNQ <= next_oeNQ;
      rdNQ <= next_rdNQ;
      wrNQ <= next_wrNQ;
    end
  end
  assign cpuHold         = busyQ;
  assign cycleStart      = startQ;
  assign reqDone         = doneQ;
  assign reqRdata        = rdataQ;
  assign clockControlReg = clkReg;
  assign memoryMapReg    = mapReg;
  assign extAddr         = addrQ;
  assign extDataOut      = wdataQ;
  assign extDataOe       = oeNQ; // low while driving
  assign readStrobeN     = rdNQ;
  assign writeStrobeN    = wrNQ;
endmodule

// *** test/xds_stretch_wait_asserts.sv ***
`timescale 1ns/1ps
module xds_stretch_wait_asserts
  import xds_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Watched ports
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              cpuHold,
  input wire logic              reqDone,
  input wire logic              cycleStart,
  input wire logic              sfrWrite,
  input wire logic              sfrSelClk,
  input wire logic              sfrSelMap,
  input wire logic [7:0]        sfrWdata,
  input wire logic [7:0]        clockControlReg,
  input wire logic [7:0]        memoryMapReg,
  input wire logic [ADDR_W-1:0] extAddr,
  input wire logic [DATA_W-1:0] extDataOut,
  input wire logic              extDataOe,
  input wire logic              readStrobeN,
  input wire logic              writeStrobeN
);
  logic       strobeOn;
  logic [7:0] lowLen;
  logic [7:0] next_lowLen;
  logic [7:0] wantLen;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  assign strobeOn = !readStrobeN || !writeStrobeN;
  // Counter, since a strobe of 28 clocks is too long for a repetition
  always_comb begin
    next_lowLen = strobeOn ? lowLen + 8'h01 : 8'h00;
    wantLen = (clockControlReg[2:0] == 3'h0) ? 8'h02 : {3'h0, clockControlReg[2:0], 2'h0};
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) lowLen <= 8'h00;
    else lowLen <= next_lowLen;
  end
  property p_fetch; $rose(cpuHold) |-> (readStrobeN && writeStrobeN)[*4]; endproperty
  a_fetch: assert property (p_fetch) else $error("strobe inside fetch cycle");
  property p_field; sfrWrite && sfrSelClk |=> clockControlReg[2:0] == $past(sfrWdata[2:0]);
  endproperty
  a_field: assert property (p_field) else $error("stretch field not written");
  property p_done; reqDone |=> !reqDone; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_width; !strobeOn && lowLen != 8'h00 |->
    (memoryMapReg[HOLD_EN_BIT] ? lowLen >= wantLen : lowLen == wantLen); endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_idle; !cpuHold |-> readStrobeN && writeStrobeN; endproperty
  a_idle: assert property (p_idle) else $error("strobe outside a move");
  property p_reset; $past(rst) |-> clockControlReg == 8'h01 && memoryMapReg == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_mc; cycleStart |=> (!cycleStart)[*3] ##1 cycleStart; endproperty
  a_mc: assert property (p_mc) else $error("machine cycle not four clocks");
  property p_lock; $rose(memoryMapReg[HOLD_EN_BIT]) |-> $past(sfrWrite && sfrSelMap); endproperty
  a_lock: assert property (p_lock) else $error("hold enable set without write");
  property p_stable; strobeOn && $past(strobeOn) |-> $stable(extAddr) &&
    (writeStrobeN || ($stable(extDataOut) && !extDataOe)); endproperty
  a_stable: assert property (p_stable) else $error("bus moved under strobe");
endmodule
bind xds_stretch_wait xds_stretch_wait_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (
  .clock(clock), .rst(rst), .cpuHold(cpuHold), .reqDone(reqDone), .cycleStart(cycleStart),
  .sfrWrite(sfrWrite), .sfrSelClk(sfrSelClk), .sfrSelMap(sfrSelMap), .sfrWdata(sfrWdata),
  .clockControlReg(clockControlReg), .memoryMapReg(memoryMapReg), .extAddr(extAddr),
  .extDataOut(extDataOut), .extDataOe(extDataOe), .readStrobeN(readStrobeN),
  .writeStrobeN(writeStrobeN)
);

// *** test/xds_ext_mem_model.sv ***
`timescale 1ns/1ps
module xds_ext_mem_model (
  // Device pins
  input wire logic        clock,
  input wire logic        readStrobeN,
  input wire logic        writeStrobeN,
  input wire logic [15:0] extAddr,
  input wire logic [7:0]  extDataOut,
  output logic [7:0]      extDataIn,
  output logic            holdRequestN,
  // Clocks of hold asked for at each strobe
  input wire logic [7:0]  holdClocks
);
  logic [7:0] mem [16];
  logic [7:0] heldFor;
  initial extDataIn = 8'h00;
  initial holdRequestN = 1'b1;
  initial heldFor = 8'h00;
  always @(posedge clock) begin
    if (!writeStrobeN) mem[extAddr[3:0]] <= extDataOut;
    // Released bus toggles so a stale byte is never mistaken for data
    extDataIn <= !readStrobeN ? mem[extAddr[3:0]] : ~extDataIn;
    heldFor <= (readStrobeN && writeStrobeN) ? 8'h00 : heldFor + 8'h01;
    holdRequestN <= (readStrobeN && writeStrobeN) || heldFor >= holdClocks;
  end
endmodule

// *** test/test_xds_stretch_wait.sv ***
`timescale 1ns/1ps
module test_xds_stretch_wait import xds_pkg::*; ;
  logic clock, rst, reqValid, reqWrite, cpuHold, reqDone, cycleStart, sfrWrite, sfrSelClk;
  logic sfrSelMap, sfrSelKey, holdRequestN, extDataOe, readStrobeN, writeStrobeN;
  logic [15:0] reqAddr, extAddr;
  logic [7:0]  reqWdata, reqRdata, sfrWdata, clockControlReg, memoryMapReg;
  logic [7:0]  extDataIn, extDataOut, holdClocks;
  int errors = 0;
  int samples_checked = 0;
  xds_stretch_wait dut_u (.clock(clock), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .cpuHold(cpuHold), .reqDone(reqDone),
    .reqRdata(reqRdata), .cycleStart(cycleStart), .sfrWrite(sfrWrite), .sfrSelClk(sfrSelClk),
    .sfrSelMap(sfrSelMap), .sfrSelKey(sfrSelKey), .sfrWdata(sfrWdata),
    .clockControlReg(clockControlReg), .memoryMapReg(memoryMapReg),
    .holdRequestN(holdRequestN), .extDataIn(extDataIn), .extAddr(extAddr),
    .extDataOut(extDataOut), .extDataOe(extDataOe), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN));
  xds_ext_mem_model mem_u (.clock(clock), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .extAddr(extAddr), .extDataOut(extDataOut),
    .extDataIn(extDataIn), .holdRequestN(holdRequestN), .holdClocks(holdClocks));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sfrWr(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clock);
    sfrWrite <= 1'b1;
    {sfrSelKey, sfrSelMap, sfrSelClk} <= sel;
    sfrWdata <= d;
    @(posedge clock);
    sfrWrite <= 1'b0;
  endtask
  task automatic move(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      output int cyc, output int wid);
    cyc = 0;
    wid = 0;
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= {12'h000, a};
    reqWdata <= d;
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      if (cpuHold) reqValid <= 1'b0;
      if (cpuHold) cyc++;
      if (!readStrobeN || !writeStrobeN) wid++;
      if (reqDone) break;
    end
  endtask
  task automatic t_sweep;
    int cyc, wid;
    for (int s = 0; s < 8; s++) begin
      sfrWr(3'h1, 8'(s));
      move(1'b1, 4'(s), 8'h30 + 8'(s), cyc, wid);
      chk("moveCycles", s + 2, (cyc + 2) / 4);
      chk("strobeWidth", (s == 0) ? 2 : 4 * s, wid);
      move(1'b0, 4'(s), 8'h00, cyc, wid);
      @(posedge clock);
      chk("readData", 8'h30 + 8'(s), reqRdata);
    end
    $display("test sweep done");
  endtask
  task automatic t_hold;
    int cyc, wid;
    sfrWr(3'h2, 8'h80);
    @(posedge clock);
    chk("lockedEnable", 1'b0, memoryMapReg[HOLD_EN_BIT]);
    sfrWr(3'h4, UNLOCK_KEY1);
    sfrWr(3'h4, UNLOCK_KEY2);
    sfrWr(3'h2, 8'h80);
    @(posedge clock);
    chk("openEnable", 1'b1, memoryMapReg[HOLD_EN_BIT]);
    sfrWr(3'h1, 8'h02);
    move(1'b1, 4'h9, 8'h5a, cyc, wid);
    chk("heldWidth", 20, wid);
    chk("heldCycles", 7, (cyc + 2) / 4);
    holdClocks <= 8'h00;
    move(1'b0, 4'h9, 8'h00, cyc, wid);
    chk("minWidth", 8, wid);
    @(posedge clock);
    chk("heldData", 8'h5a, reqRdata);
    $display("test hold done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clock);
    errors++;
    report_and_stop();
  end
  initial begin
    {rst, reqValid, reqWrite, sfrWrite, sfrSelClk, sfrSelMap, sfrSelKey} = 7'h40;
    reqAddr = 16'h0000;
    {reqWdata, sfrWdata} = 16'h0000;
    holdClocks = 8'h0c;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("clockControlReg", 8'h01, clockControlReg);
    chk("memoryMapReg", 8'h00, memoryMapReg);
    t_sweep();
    t_hold();
    report_and_stop();
  end
endmodule
